// File: dv/scol_controller_model.sv
// Controller-side model: link and auxiliary clocks, output pace counters
`timescale 1ns/1ps
module scol_controller_model (
    output logic linkClkIn,
    output logic auxClkIn,
    input wire logic clkOut,
    output int linkEdges,
    output int outToggles
);
    // ========================================
    // Clock sources
    // Link clock runs free at 5 MHz, well inside the sampling reach
    initial begin
        linkClkIn = 1'b0;
        forever #100 linkClkIn = ~linkClkIn;
    end
    // Auxiliary clock at 10 MHz, needed only by the temperature path
    initial begin
        auxClkIn = 1'b0;
        forever #50 auxClkIn = ~auxClkIn;
    end
    // ========================================
    // Receiver side
    // Count link edges and output clock toggles so the pace can be compared
    initial linkEdges = 0;
    always @(posedge linkClkIn) linkEdges <= linkEdges + 1;
    initial outToggles = 0;
    always @(clkOut) outToggles <= outToggles + 1;
endmodule // scol_controller_model

// File: dv/scol_sensor_properties.sv
// Concurrent checks on the ports of the sensor block
`timescale 1ns/1ps
module scol_sensor_properties (
    input wire logic clock,
    input wire logic rst,
    input wire logic linkClkIn,
    input wire logic auxClkIn,
    input wire logic system_reset_low,
    input wire logic frameRequest,
    input wire logic exposure_pulse_primary,
    input wire logic exposure_pulse_secondary,
    input wire logic spiClk,
    input wire logic spiSelect,
    input wire logic spiDataIn,
    input wire logic [scol_pkg::REG_BITS-1:0] tempSensorCode,
    input wire logic spiDataOut,
    input wire logic [scol_pkg::DATA_CHANNELS-1:0] dataOut,
    input wire logic ctrlOut,
    input wire logic clkOut
);
    import scol_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic clkOutPrev_r;
    logic [4:0] sinceToggle_r;
    logic [7:0] reqHigh_r;
    // ========================================
    // Helper counters
    // Cycles since the output clock last moved, cleared in any reset
    always_ff @(posedge clock) begin
        clkOutPrev_r <= clkOut;
        if (rst || !system_reset_low || clkOut != clkOutPrev_r) begin
            sinceToggle_r <= 5'h00;
        end else if (sinceToggle_r != 5'h1f) begin
            sinceToggle_r <= sinceToggle_r + 5'h01;
        end
    end
    // Length of the current high level on the frame request pin
    always_ff @(posedge clock) begin
        if (rst || !system_reset_low || !frameRequest) begin
            reqHigh_r <= 8'h00;
        end else if (reqHigh_r != 8'hff) begin
            reqHigh_r <= reqHigh_r + 8'h01;
        end
    end
    // ========================================
    // Sequences
    sequence spi_high_s;
        (spiClk && spiSelect) [*5];
    endsequence
    sequence req_long_s;
        reqHigh_r == 8'h78;
    endsequence
    // ========================================
    // Assertions
    reset_quiet_a: assert property ($fell(rst) |-> dataOut == '0 &&
        !ctrlOut && !clkOut && !spiDataOut) else $error("outputs not idle");
    sysreset_quiet_a: assert property (!system_reset_low [*5] |=>
        dataOut == '0 && !ctrlOut && !clkOut) else $error("system reset ignored");
    clk_pace_a: assert property (disable iff (rst || !system_reset_low)
        $changed(clkOut) |=> $stable(clkOut) [*5]) else $error("clock too fast");
    clk_alive_a: assert property (disable iff (rst || !system_reset_low)
        sinceToggle_r <= 5'h14) else $error("output clock stalled");
    out_pace_a: assert property (disable iff (rst || !system_reset_low)
        $changed({dataOut, ctrlOut}) |=> $stable({dataOut, ctrlOut}) [*5])
        else $error("output bits off pace");
    spi_idle_a: assert property (!spiSelect [*5] |-> !spiDataOut)
        else $error("read line busy without select");
    spi_hold_a: assert property (spi_high_s |=> $stable(spiDataOut))
        else $error("read bit moved while clock high");
    frame_start_a: assert property (disable iff (rst || !system_reset_low)
        req_long_s |-> ##[0:300] ctrlOut) else $error("frame not started");
endmodule // scol_sensor_properties

bind scol_sensor scol_sensor_properties chk (.clock(clock), .rst(rst),
    .linkClkIn(linkClkIn), .auxClkIn(auxClkIn),
    .system_reset_low(system_reset_low), .frameRequest(frameRequest),
    .exposure_pulse_primary(exposure_pulse_primary),
    .exposure_pulse_secondary(exposure_pulse_secondary),
    .spiClk(spiClk), .spiSelect(spiSelect), .spiDataIn(spiDataIn),
    .tempSensorCode(tempSensorCode), .spiDataOut(spiDataOut),
    .dataOut(dataOut), .ctrlOut(ctrlOut), .clkOut(clkOut));

// File: dv/tb_top.sv
// Self-checking bench for the sensor sequencer, port and output link
`timescale 1ns/1ps
module tb_top;
    import scol_pkg::*;
    logic clock, rst, linkClkIn, auxClkIn, system_reset_low, frameRequest;
    logic exposure_pulse_primary, exposure_pulse_secondary;
    logic spiClk, spiSelect, spiDataIn, spiDataOut, ctrlOut, clkOut;
    logic [REG_BITS-1:0] tempSensorCode;
    logic [DATA_CHANNELS-1:0] dataOut;
    int nFail, samplesChecked, linkEdges, outToggles, e0, t0;
    // ========================================
    // Design, controller model and clock
    scol_sensor dut (.clock(clock), .rst(rst), .linkClkIn(linkClkIn),
        .auxClkIn(auxClkIn), .system_reset_low(system_reset_low),
        .frameRequest(frameRequest),
        .exposure_pulse_primary(exposure_pulse_primary),
        .exposure_pulse_secondary(exposure_pulse_secondary), .spiClk(spiClk),
        .spiSelect(spiSelect), .spiDataIn(spiDataIn),
        .tempSensorCode(tempSensorCode), .spiDataOut(spiDataOut),
        .dataOut(dataOut), .ctrlOut(ctrlOut), .clkOut(clkOut));
    scol_controller_model ctl (.linkClkIn(linkClkIn), .auxClkIn(auxClkIn),
        .clkOut(clkOut), .linkEdges(linkEdges), .outToggles(outToggles));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ========================================
    // Tasks
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic check_val(input logic [15:0] seen, input logic [15:0] want);
        samplesChecked++;
        if (seen !== want) begin
            nFail++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, want);
        end
    endtask
    // One 24-bit transfer, slow enough for the 40 MHz sampling
    task automatic spi_xfer(input logic wr, input logic [6:0] addr,
            input logic [15:0] wdata, output logic [15:0] rdata);
        logic [23:0] word;
        word = {wr, addr, wdata};
        rdata = 16'h0000;
        spiSelect = 1'b1;
        tick(6);
        for (int i = 23; i >= 0; i--) begin
            spiDataIn = word[i];
            tick(6);
            if (i < 16) rdata[i] = spiDataOut;
            spiClk = 1'b1;
            tick(6);
            spiClk = 1'b0;
        end
        tick(12);
        spiSelect = 1'b0;
        spiDataIn = 1'b0;
        tick(6);
    endtask
    task automatic rd_check(input logic [6:0] addr, input logic [15:0] want);
        logic [15:0] rd;
        spi_xfer(1'b0, addr, 16'h0000, rd);
        check_val(rd, want);
    endtask
    task automatic wr_reg(input logic [6:0] addr, input logic [15:0] wdata);
        logic [15:0] rd;
        spi_xfer(1'b1, addr, wdata, rd);
    endtask
    task automatic req_pulse(input int links);
        frameRequest = 1'b1;
        tick(links * 8);
        frameRequest = 1'b0;
    endtask
    // Pin reset, then the settle time before any request or upload
    task automatic sys_reset;
        system_reset_low = 1'b0;
        tick(20);
        system_reset_low = 1'b1;
        tick(40);
    endtask
    // Both exposure pins high for the given number of link periods
    task automatic exp_pulse(input int links);
        exposure_pulse_primary = 1'b1;
        exposure_pulse_secondary = 1'b1;
        tick(links * 8);
        exposure_pulse_primary = 1'b0;
        exposure_pulse_secondary = 1'b0;
    endtask
    task automatic expect_quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            tick(1);
            if (dataOut !== '0) seen = 1'b1;
        end
        check_val({15'h0000, seen}, 16'h0000);
    endtask
    task automatic expect_active(input int n);
        int k;
        k = 0;
        while (dataOut === '0 && k < n) begin
            tick(1);
            k++;
        end
        check_val({15'h0000, dataOut !== '0}, 16'h0001);
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ========================================
    // Tests
    // Watchdog, far beyond the expected run of about 13500 cycles
    initial begin
        repeat (60000) @(posedge clock);
        nFail++;
        $display("BAD t=%0t run did not finish", $time);
        close_out;
    end
    // Main sequence of register and frame scenarios
    initial begin
        {rst, system_reset_low, frameRequest} = 3'b100;
        {spiClk, spiSelect, spiDataIn} = 3'b000;
        {exposure_pulse_primary, exposure_pulse_secondary} = 2'b00;
        tempSensorCode = 16'h5a3c;
        tick(8);
        rst = 1'b0;
        tick(4);
        system_reset_low = 1'b1;
        tick(40);
        rd_check(REG_PIXEL_RESOLUTION_SELECT, RESOLUTION_RESET);
        rd_check(REG_FRAME_COUNT, FRAME_COUNT_RESET);
        rd_check(REG_EXPOSURE_TIME, EXPOSURE_TIME_RESET);
        rd_check(REG_DIE_TEMPERATURE, 16'h5a3c);
        wr_reg(REG_DIE_TEMPERATURE, 16'ha5c3);
        tempSensorCode = 16'h3c5a;
        rd_check(REG_DIE_TEMPERATURE, 16'h3c5a);
        req_pulse(9);
        expect_quiet(2000);
        sys_reset;
        wr_reg(REG_PIXEL_RESOLUTION_SELECT, {14'h0000, RES_8BIT});
        rd_check(REG_PIXEL_RESOLUTION_SELECT, {14'h0000, RES_8BIT});
        req_pulse(9);
        expect_active(600);
        e0 = linkEdges;
        t0 = outToggles;
        tick(3000);
        check_val({15'h0000, (outToggles - t0) - (linkEdges - e0) <= 1 &&
            (linkEdges - e0) - (outToggles - t0) <= 1}, 16'h0001);
        expect_quiet(2000);
        sys_reset;
        rd_check(REG_PIXEL_RESOLUTION_SELECT, RESOLUTION_RESET);
        req_pulse(16);
        expect_active(3000);
        // External exposure: pin starts it, frame request ends it
        tick(1800);
        wr_reg(REG_EXPOSURE_MODE, 16'h0001);
        exp_pulse(16);
        expect_quiet(400);
        req_pulse(16);
        expect_active(600);
        close_out;
    end
endmodule // tb_top

// File: verilog/scol_pkg.sv
// Constants shared by the sensor control and output link block
package scol_pkg;
    // ========================================
    // Link geometry
    localparam int DATA_CHANNELS = 64;
    localparam int MAX_WORD_BITS = 12;
    localparam int REG_COUNT = 128;
    localparam int ADDR_BITS = 7;
    localparam int REG_BITS = 16;
    localparam int SPI_FRAME_BITS = 24;
    // ========================================
    // Register addresses
    localparam logic [6:0] REG_EXPOSURE_MODE = 7'h46;
    localparam logic [6:0] REG_EXPOSURE_TIME = 7'h47;
    localparam logic [6:0] REG_FRAME_COUNT = 7'h50;
    localparam logic [6:0] REG_PIXEL_RESOLUTION_SELECT = 7'h76;
    localparam logic [6:0] REG_DIE_TEMPERATURE = 7'h7f;
    // ========================================
    // Field positions
    localparam int EXT_EXPOSURE_BIT = 0;
    // ========================================
    // Reset values
    localparam logic [15:0] FRAME_COUNT_RESET = 16'h0001;
    localparam logic [15:0] RESOLUTION_RESET = 16'h0000;
    localparam logic [15:0] EXPOSURE_TIME_RESET = 16'h0010;
    localparam logic [15:0] OTHER_REG_RESET = 16'h0000;
    // ========================================
    // Resolution codes
    localparam logic [1:0] RES_12BIT = 2'h0;
    localparam logic [1:0] RES_10BIT = 2'h1;
    localparam logic [1:0] RES_8BIT = 2'h2;
    // ========================================
    // Timing counts in link clock periods, and words per readout frame
    localparam logic [3:0] MIN_PULSE_12 = 4'hc;
    localparam logic [3:0] MIN_PULSE_10 = 4'ha;
    localparam logic [3:0] MIN_PULSE_8 = 4'h8;
    localparam logic [7:0] READOUT_WORDS = 8'h10;
    localparam logic [3:0] FOT_CYCLES = 4'h4;
    // ========================================
    // Sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_EXPOSE = 2'b01,
        SEQ_FOT = 2'b11,
        SEQ_READOUT = 2'b10
    } scol_seq_type;
endpackage

// File: verilog/scol_sensor.sv
// Sensor sequencer, programming port and serial output link
// ========================================
`timescale 1ns/1ps
module scol_sensor (
    input wire logic clock,
    input wire logic rst,
    input wire logic linkClkIn,
    input wire logic auxClkIn,
    input wire logic system_reset_low,
    input wire logic frameRequest,
    input wire logic exposure_pulse_primary,
    input wire logic exposure_pulse_secondary,
    input wire logic spiClk,
    input wire logic spiSelect,
    input wire logic spiDataIn,
    input wire logic [scol_pkg::REG_BITS-1:0] tempSensorCode,
    output logic spiDataOut,
    output logic [scol_pkg::DATA_CHANNELS-1:0] dataOut,
    output logic ctrlOut,
    output logic clkOut
);
    import scol_pkg::*;

    // ========================================
    // Input synchronisers
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] pinRaw;
    logic [NSYNC-1:0] syncA_r;
    logic [NSYNC-1:0] syncB_r;
    logic [NSYNC-1:0] syncC_r;
    assign pinRaw = {auxClkIn, spiDataIn, spiSelect,
                     spiClk, exposure_pulse_secondary, exposure_pulse_primary,
                     frameRequest, system_reset_low, linkClkIn};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            // Two stages, then one more for edge detection
            always_ff @(posedge clock) begin
                syncA_r[gi] <= pinRaw[gi];
                syncB_r[gi] <= syncA_r[gi];
                syncC_r[gi] <= syncB_r[gi];
            end
        end
    endgenerate

    logic linkEdge, resLevelN, resFall, auxEdge;
    logic spiRise, spiFall, selLevel, spiBit;
    assign linkEdge = syncB_r[0] & ~syncC_r[0];
    assign resLevelN = syncB_r[1];
    assign resFall = ~syncB_r[1] & syncC_r[1];
    assign spiRise = syncB_r[5] & ~syncC_r[5];
    assign spiFall = ~syncB_r[5] & syncC_r[5];
    assign selLevel = syncB_r[6];
    assign spiBit = syncB_r[7];
    assign auxEdge = syncB_r[8] & ~syncC_r[8];

    // Sequencer reset: power reset, low level or falling edge of pin
    logic seqReset;
    assign seqReset = rst | resFall | ~resLevelN;

    // ========================================
    // Register file and programming port
    logic [REG_BITS-1:0] regFile [0:REG_COUNT-1];
    logic [REG_BITS-1:0] tempCode_r;
    logic [SPI_FRAME_BITS-1:0] spiShift_r;
    logic [4:0] spiCount_r;
    logic [REG_BITS-1:0] readShift_r;
    logic readActive_r;
    logic writePend_r;
    logic [1:0] resolution;
    logic [3:0] minPulse;
    logic [3:0] wordBits;
    assign resolution = regFile[REG_PIXEL_RESOLUTION_SELECT][1:0];

    // Temperature sampled on the auxiliary clock
    always_ff @(posedge clock) begin
        if (rst) begin
            tempCode_r <= OTHER_REG_RESET;
        end else if (auxEdge) begin
            tempCode_r <= tempSensorCode;
        end
    end

    // Shift in address and data while select is high
    always_ff @(posedge clock) begin
        if (seqReset || !selLevel) begin
            spiShift_r <= 24'h000000;
            spiCount_r <= 5'h00;
            writePend_r <= 1'b0;
        end else if (spiRise) begin
            spiShift_r <= {spiShift_r[SPI_FRAME_BITS-2:0], spiBit};
            if (spiCount_r == 5'(SPI_FRAME_BITS - 1)) begin
                spiCount_r <= 5'h00;
                writePend_r <= spiShift_r[SPI_FRAME_BITS-2];
            end else begin
                spiCount_r <= spiCount_r + 5'h01;
            end
        end else if (spiFall) begin
            writePend_r <= 1'b0;
        end
    end

    // Read data launched on falling edges after the last address bit
    always_ff @(posedge clock) begin
        if (seqReset || !selLevel) begin
            readShift_r <= 16'h0000;
            readActive_r <= 1'b0;
            spiDataOut <= 1'b0;
        end else if (spiRise && spiCount_r == 5'h07 && !spiShift_r[6]) begin
            readActive_r <= 1'b1;
            if ({spiShift_r[5:0], spiBit} == REG_DIE_TEMPERATURE) begin
                readShift_r <= tempCode_r;
            end else begin
                readShift_r <= regFile[{spiShift_r[5:0], spiBit}];
            end
        end else if (spiFall && readActive_r) begin
            spiDataOut <= readShift_r[REG_BITS-1];
            readShift_r <= {readShift_r[REG_BITS-2:0], 1'b0};
            if (spiCount_r == 5'h00) begin
                readActive_r <= 1'b0;
            end
        end
    end

    // Register storage; write commits on falling edge after the 24th bit
    always_ff @(posedge clock) begin
        if (seqReset) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regFile[i] <= OTHER_REG_RESET;
            end
            regFile[REG_FRAME_COUNT] <= FRAME_COUNT_RESET;
            regFile[REG_PIXEL_RESOLUTION_SELECT] <= RESOLUTION_RESET;
            regFile[REG_EXPOSURE_TIME] <= EXPOSURE_TIME_RESET;
        end else if (spiFall && writePend_r
                     && spiShift_r[22:16] != REG_DIE_TEMPERATURE) begin
            regFile[spiShift_r[22:16]] <= spiShift_r[15:0];
        end
    end

    // ========================================
    // Minimum pulse filters for request and exposure inputs
    always_comb begin
        unique case (resolution)
            RES_10BIT: begin
                minPulse = MIN_PULSE_10;
                wordBits = 4'ha;
            end
            RES_8BIT: begin
                minPulse = MIN_PULSE_8;
                wordBits = 4'h8;
            end
            default: begin
                minPulse = MIN_PULSE_12;
                wordBits = 4'hc;
            end
        endcase
    end

    logic [2:0] detected_r;
    logic [2:0] detPrev_r;
    logic [2:0] detRise;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_filt
            logic [3:0] stable_r;
            // Count link periods of steady high level
            always_ff @(posedge clock) begin
                if (seqReset || !syncB_r[2+gi]) begin
                    stable_r <= 4'h0;
                    detected_r[gi] <= 1'b0;
                end else if (linkEdge && !detected_r[gi]) begin
                    stable_r <= stable_r + 4'h1;
                    if (stable_r + 4'h1 >= minPulse) begin
                        detected_r[gi] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // Rising edges of filtered levels
    always_ff @(posedge clock) begin
        if (seqReset) begin
            detPrev_r <= 3'h0;
        end else begin
            detPrev_r <= detected_r;
        end
    end
    assign detRise = detected_r & ~detPrev_r;

    // ========================================
    // Sequencer
    scol_seq_type state_r;
    logic [15:0] framesLeft_r;
    logic [15:0] phaseCnt_r;
    logic [1:0] pending_r;
    logic [3:0] bitIdx_r;
    logic [7:0] wordCnt_r;
    logic extMode, lastBit, reqNow;
    assign extMode = regFile[REG_EXPOSURE_MODE][EXT_EXPOSURE_BIT];
    assign lastBit = (bitIdx_r == wordBits - 4'h1);
    assign reqNow = detRise[0] | (detected_r[0] & state_r == SEQ_IDLE);

    // Remember up to two early requests
    always_ff @(posedge clock) begin
        if (seqReset) begin
            pending_r <= 2'h0;
        end else if (reqNow && state_r != SEQ_IDLE
                     && !(extMode && state_r == SEQ_EXPOSE)) begin
            if (pending_r != 2'h2) begin
                pending_r <= pending_r + 2'h1;
            end
        end else if (state_r == SEQ_IDLE && pending_r != 2'h0) begin
            pending_r <= pending_r - 2'h1;
        end
    end

    // Exposure, frame overhead and readout sequencing
    always_ff @(posedge clock) begin
        if (seqReset) begin
            state_r <= SEQ_IDLE;
            framesLeft_r <= 16'h0000;
            phaseCnt_r <= 16'h0000;
        end else begin
            unique case (state_r)
                SEQ_IDLE: begin
                    phaseCnt_r <= 16'h0000;
                    if (extMode ? detRise[1] : (reqNow || pending_r != 2'h0)) begin
                        state_r <= SEQ_EXPOSE;
                        if (framesLeft_r == 16'h0000) begin
                            framesLeft_r <= regFile[REG_FRAME_COUNT];
                        end
                    end else if (framesLeft_r != 16'h0000 && !extMode) begin
                        state_r <= SEQ_EXPOSE;
                    end
                end
                SEQ_EXPOSE: begin
                    if (extMode ? reqNow : linkEdge) begin
                        phaseCnt_r <= phaseCnt_r + 16'h0001;
                        if (extMode || phaseCnt_r + 16'h0001
                                >= regFile[REG_EXPOSURE_TIME]) begin
                            state_r <= SEQ_FOT;
                            phaseCnt_r <= 16'h0000;
                        end
                    end
                end
                SEQ_FOT: begin
                    if (linkEdge) begin
                        phaseCnt_r <= phaseCnt_r + 16'h0001;
                        if (phaseCnt_r[3:0] == FOT_CYCLES - 4'h1) begin
                            state_r <= SEQ_READOUT;
                        end
                    end
                end
                SEQ_READOUT: begin
                    if (linkEdge && lastBit
                            && wordCnt_r == READOUT_WORDS - 8'h01) begin
                        state_r <= SEQ_IDLE;
                        if (framesLeft_r != 16'h0000) begin
                            framesLeft_r <= framesLeft_r - 16'h0001;
                        end
                    end
                end
            endcase
        end
    end

    // Bit and word position within the frame
    always_ff @(posedge clock) begin
        if (seqReset || state_r != SEQ_READOUT) begin
            bitIdx_r <= 4'h0;
            wordCnt_r <= 8'h00;
        end else if (linkEdge) begin
            bitIdx_r <= lastBit ? 4'h0 : bitIdx_r + 4'h1;
            if (lastBit) begin
                wordCnt_r <= wordCnt_r + 8'h01;
            end
        end
    end

    // ========================================
    // Serial output link
    logic [3:0] msbPos;
    logic [11:0] ctrlWord;
    assign msbPos = wordBits - 4'h1 - bitIdx_r;
    assign ctrlWord = {state_r == SEQ_READOUT, state_r != SEQ_IDLE,
                       state_r == SEQ_EXPOSE, detected_r[2], 8'h00};
    generate
        for (gi = 0; gi < DATA_CHANNELS; gi++) begin : g_chan
            logic [11:0] pixWord;
            assign pixWord = {wordCnt_r[5:0], 6'(gi)};
            // Pixel word shifted MSB first, zero outside readout
            always_ff @(posedge clock) begin
                if (seqReset) begin
                    dataOut[gi] <= 1'b0;
                end else if (linkEdge) begin
                    dataOut[gi] <= (state_r == SEQ_READOUT)
                                   & pixWord[msbPos];
                end
            end
        end
    endgenerate

    // Control word and DDR clock
    always_ff @(posedge clock) begin
        if (seqReset) begin
            ctrlOut <= 1'b0;
            clkOut <= 1'b0;
        end else if (linkEdge) begin
            ctrlOut <= ctrlWord[4'hb - bitIdx_r];
            clkOut <= ~clkOut;
        end
    end
endmodule // scol_sensor
